// *** rtl/ccip_pkg.sv ***
// Purpose: shared constants for the completion interrupt pending block
// Assumes: 32-bit register port with 8-bit byte addresses
// Notes: offsets are byte addresses, one aligned word per register

package ccip_pkg;

  // ==========================================================
  // widths
  localparam int CCIP_DW = 32;
  localparam int CCIP_AW = 8;
  localparam int CCIP_CODE_W = 6;
  localparam int CCIP_NCODE = 64;
  localparam int CCIP_SHADOW_DEF = 8;

  typedef logic [CCIP_DW-1:0] ccip_word_type;
  typedef logic [CCIP_AW-1:0] ccip_addr_type;

  // ==========================================================
  // register offsets
  localparam ccip_addr_type CCIP_PEND_LO = 8'h00;
  localparam ccip_addr_type CCIP_PEND_HI = 8'h04;
  localparam ccip_addr_type CCIP_CLR_LO = 8'h08;
  localparam ccip_addr_type CCIP_CLR_HI = 8'h0c;
  localparam ccip_addr_type CCIP_EN_LO = 8'h10;
  localparam ccip_addr_type CCIP_EN_HI = 8'h14;
  localparam ccip_addr_type CCIP_EN_SET_LO = 8'h18;
  localparam ccip_addr_type CCIP_EN_SET_HI = 8'h1c;
  localparam ccip_addr_type CCIP_EN_CLR_LO = 8'h20;
  localparam ccip_addr_type CCIP_EN_CLR_HI = 8'h24;
  localparam ccip_addr_type CCIP_REEVALUATE_BIT_BASE = 8'h40;
  localparam ccip_addr_type CCIP_REEVALUATE_BIT_STEP = 8'h04;

  // ==========================================================
  // fields and reset values
  localparam int CCIP_REEVALUATE_BIT_BIT = 0;
  localparam int CCIP_REEVALUATE_BIT_RSVD_BIT = 1;
  localparam int CCIP_UPPER_BIT = 5;
  localparam ccip_word_type CCIP_PEND_RST = 32'h0000_0000;
  localparam ccip_word_type CCIP_EN_RST = 32'h0000_0000;
  localparam ccip_word_type CCIP_ZERO = 32'h0000_0000;

endpackage : ccip_pkg

// *** rtl/ccip_region_pulse.sv ***
// Purpose: completion interrupt pulse for one region
// Assumes: masked holds pending and enable and access, ANDed combinationally
// Notes: pulse lasts one enabled clock

`timescale 1ns/10ps

module ccip_region_pulse
  import ccip_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [ccip_pkg::CCIP_NCODE-1:0] masked,
  input wire logic reevaluate_bit_wr,
  output logic pulse_r
);

  import ccip_pkg::*;

  logic any_pend;
  logic any_r;
  logic pulse_nxt;

  // ==========================================================
  // pulse generation
  assign any_pend = |masked;
  // first enabled pending, or re-evaluate while still pending
  assign pulse_nxt = (any_pend & ~any_r) | (reevaluate_bit_wr & any_pend);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      any_r <= 1'b0;
    end else if (clk_en) begin
      any_r <= any_pend;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pulse_r <= 1'b0;
    end else if (clk_en) begin
      pulse_r <= pulse_nxt;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  AST_REEVALUATE_BIT_PULSE: assert property (clk_en && reevaluate_bit_wr && any_pend |=> pulse_r)
    else $error("evaluate with pending did not pulse");
  AST_REEVALUATE_BIT_NONE: assert property (clk_en && reevaluate_bit_wr && !any_pend |=> !pulse_r)
    else $error("evaluate without pending pulsed");
  AST_NO_REPULSE: assert property (clk_en && any_r && !reevaluate_bit_wr |=> !pulse_r)
    else $error("pulse while earlier pending uncleared");
  AST_FIRST_PEND: assert property (clk_en && any_pend && !any_r |=> pulse_r)
    else $error("new enabled pending did not pulse");
  COV_REEVALUATE_BIT_REPULSE: cover property (clk_en && reevaluate_bit_wr && any_r ##1 pulse_r);

endmodule : ccip_region_pulse

// *** rtl/ccip_top.sv ***
// What this block does
// - completion code 32 to 63 sets matching upper pending bit 31-0
// - pending 1 means code detected; 0 means not or cleared; code is 6 bits
// - writing 1 to lower clear bit clears lower pending; 0 does nothing
// - writing 1 to upper clear bit clears upper pending; clears read zero
// - no further interrupt until every enabled, accessible pending bit is cleared
// - evaluate exists in global and every shadow region, ignoring access enables
// - evaluate bit 0 written 1 pulses interrupt if enabled pending remains
// - pulse goes only to the region whose evaluate copy was written
// - codes 0 to 31 set lower pending; bits stay set until cleared
// - writing 1 to enable set bit sets enable; 0 does nothing
// - writing 1 to upper enable clear bit clears upper enable
//
// Purpose: completion pending bits, enables and region interrupts
// Assumes: completion codes arrive on ref_clk from on-chip logic
// Notes: region 0 is global, regions 1.. are shadow regions

`timescale 1ns/10ps

module ccip_top
  import ccip_pkg::*;
#(
  parameter int NUM_SHADOW = ccip_pkg::CCIP_SHADOW_DEF
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [ccip_pkg::CCIP_AW-1:0] reg_addr,
  input wire logic [ccip_pkg::CCIP_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ccip_pkg::CCIP_DW-1:0] reg_rdata,
  input wire logic completion_valid,
  input wire logic [ccip_pkg::CCIP_CODE_W-1:0] completion_code,
  input wire logic [NUM_SHADOW*ccip_pkg::CCIP_NCODE-1:0] dma_region_access_enable,
  output logic [NUM_SHADOW:0] completion_pulse,
  output logic irq
);

  import ccip_pkg::*;

  localparam int NREG = NUM_SHADOW + 1;

  // ==========================================================
  // helpers
  function automatic logic [CCIP_NCODE-1:0] ccip_code_onehot(
    input logic [CCIP_CODE_W-1:0] code
  );
    ccip_code_onehot = 64'h1 << code;
  endfunction : ccip_code_onehot

  function automatic ccip_addr_type ccip_reevaluate_bit_addr(input int region);
    ccip_reevaluate_bit_addr = CCIP_REEVALUATE_BIT_BASE + CCIP_REEVALUATE_BIT_STEP * ccip_addr_type'(region);
  endfunction : ccip_reevaluate_bit_addr

  // ==========================================================
  // declarations
  logic wr_en;
  logic rd_en;
  logic [CCIP_NCODE-1:0] code_set;
  logic [CCIP_DW-1:0] set_lo;
  logic [CCIP_DW-1:0] set_hi;
  logic [CCIP_DW-1:0] clr_lo;
  logic [CCIP_DW-1:0] clr_hi;
  logic [CCIP_DW-1:0] pend_lo_r;
  logic [CCIP_DW-1:0] pend_hi_r;
  logic [CCIP_DW-1:0] pend_lo_nxt;
  logic [CCIP_DW-1:0] pend_hi_nxt;
  logic [CCIP_DW-1:0] en_lo_r;
  logic [CCIP_DW-1:0] en_hi_r;
  logic [CCIP_DW-1:0] rdata_nxt;
  logic [CCIP_DW-1:0] rdata_r;
  logic [CCIP_NCODE-1:0] pend_all;
  logic [CCIP_NCODE-1:0] en_all;
  logic [NREG-1:0] reevaluate_bit_wr;
  logic irq_r;
  logic [4:0] code_idx;

  assign wr_en = reg_wr & clk_en;
  assign rd_en = reg_rd & clk_en;
  assign code_idx = completion_code[4:0];

  // ==========================================================
  // completion code capture
  // six-bit code picks one of 64 pending bits
  assign code_set = completion_valid ? ccip_code_onehot(completion_code) : 64'h0;
  assign set_lo = code_set[CCIP_DW-1:0];
  assign set_hi = code_set[CCIP_NCODE-1:CCIP_DW];

  // ==========================================================
  // clear decode
  assign clr_lo = (wr_en && reg_addr == CCIP_CLR_LO) ? reg_wdata : CCIP_ZERO;
  assign clr_hi = (wr_en && reg_addr == CCIP_CLR_HI) ? reg_wdata : CCIP_ZERO;

  // ==========================================================
  // pending bits
  // set wins over a clear in the same cycle
  assign pend_lo_nxt = (pend_lo_r & ~clr_lo) | set_lo;
  assign pend_hi_nxt = (pend_hi_r & ~clr_hi) | set_hi;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pend_lo_r <= CCIP_PEND_RST;
    end else if (clk_en) begin
      pend_lo_r <= pend_lo_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pend_hi_r <= CCIP_PEND_RST;
    end else if (clk_en) begin
      pend_hi_r <= pend_hi_nxt;
    end
  end

  // ==========================================================
  // interrupt enables
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      en_lo_r <= CCIP_EN_RST;
    end else if (wr_en && reg_addr == CCIP_EN_SET_LO) begin
      en_lo_r <= en_lo_r | reg_wdata;
    end else if (wr_en && reg_addr == CCIP_EN_CLR_LO) begin
      en_lo_r <= en_lo_r & ~reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      en_hi_r <= CCIP_EN_RST;
    end else if (wr_en && reg_addr == CCIP_EN_SET_HI) begin
      en_hi_r <= en_hi_r | reg_wdata;
    end else if (wr_en && reg_addr == CCIP_EN_CLR_HI) begin
      en_hi_r <= en_hi_r & ~reg_wdata;
    end
  end

  assign pend_all = {pend_hi_r, pend_lo_r};
  assign en_all = {en_hi_r, en_lo_r};

  // ==========================================================
  // region interrupts
  genvar r;
  generate
    for (r = 0; r < NREG; r++) begin : g_region
      logic [CCIP_NCODE-1:0] access;
      logic [CCIP_NCODE-1:0] masked;
      if (r == 0) begin : g_global
        assign access = {CCIP_NCODE{1'b1}};
      end else begin : g_shadow
        assign access = dma_region_access_enable[(r-1)*CCIP_NCODE +: CCIP_NCODE];
      end
      assign masked = pend_all & en_all & access;
      // every copy decodes its own address, with no access check
      assign reevaluate_bit_wr[r] = wr_en && reg_addr == ccip_reevaluate_bit_addr(r) &&
                          reg_wdata[CCIP_REEVALUATE_BIT_BIT];
      ccip_region_pulse u_pulse (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .masked(masked),
        .reevaluate_bit_wr(reevaluate_bit_wr[r]),
        .pulse_r(completion_pulse[r])
      );
    end
  endgenerate

  // ==========================================================
  // level interrupt
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_r <= 1'b0;
    end else if (clk_en) begin
      irq_r <= |(pend_all & en_all);
    end
  end

  assign irq = irq_r;

  // ==========================================================
  // register read
  // clear, enable set/clear and evaluate words read zero
  always_comb begin
    rdata_nxt = CCIP_ZERO;
    unique case (reg_addr)
      CCIP_PEND_LO: begin
        rdata_nxt = pend_lo_r;
      end
      CCIP_PEND_HI: begin
        rdata_nxt = pend_hi_r;
      end
      CCIP_EN_LO: begin
        rdata_nxt = en_lo_r;
      end
      CCIP_EN_HI: begin
        rdata_nxt = en_hi_r;
      end
      default: begin
        rdata_nxt = CCIP_ZERO;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= CCIP_ZERO;
    end else if (clk_en) begin
      rdata_r <= rd_en ? rdata_nxt : CCIP_ZERO;
    end
  end

  assign reg_rdata = rdata_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  AST_UPPER_SET: assert property (clk_en && completion_valid && completion_code[5]
    |=> pend_hi_r[$past(code_idx)])
    else $error("upper code did not set upper pending bit");
  AST_LOWER_SET: assert property (clk_en && completion_valid && !completion_code[5]
    |=> pend_lo_r[$past(code_idx)])
    else $error("lower code did not set lower pending bit");
  AST_PEND_HOLD: assert property (clk_en && !(wr_en && reg_addr == CCIP_CLR_LO)
    |=> (pend_lo_r & $past(pend_lo_r)) == $past(pend_lo_r))
    else $error("lower pending bit fell without clear");
  AST_CLR_LO: assert property (wr_en && reg_addr == CCIP_CLR_LO && !completion_valid
    |=> (pend_lo_r & $past(reg_wdata)) == 32'h0000_0000)
    else $error("lower clear did not clear");
  AST_CLR_HI: assert property (wr_en && reg_addr == CCIP_CLR_HI && !completion_valid
    |=> (pend_hi_r & $past(reg_wdata)) == 32'h0000_0000)
    else $error("upper clear did not clear");
  AST_WO_READ: assert property (rd_en && (reg_addr == CCIP_CLR_LO ||
    reg_addr == CCIP_CLR_HI) |=> reg_rdata == 32'h0000_0000)
    else $error("clear register read nonzero");
  AST_PEND_READ: assert property (rd_en && reg_addr == CCIP_PEND_HI
    |=> reg_rdata == $past(pend_hi_r))
    else $error("upper pending read mismatch");
  AST_EN_SET: assert property (wr_en && reg_addr == CCIP_EN_SET_LO
    |=> (en_lo_r & $past(reg_wdata)) == $past(reg_wdata))
    else $error("enable set did not set");
  AST_EN_CLR_HI: assert property (wr_en && reg_addr == CCIP_EN_CLR_HI
    |=> (en_hi_r & $past(reg_wdata)) == 32'h0000_0000)
    else $error("upper enable clear did not clear");
  AST_REEVALUATE_BIT_REGION: assert property (wr_en && reg_addr == CCIP_REEVALUATE_BIT_BASE &&
    reg_wdata[0] |-> reevaluate_bit_wr == NREG'(1))
    else $error("global evaluate reached another region");
  AST_REEVALUATE_BIT_SHADOW: assert property (wr_en && reg_addr == 8'h44 && reg_wdata[0]
    |-> reevaluate_bit_wr[1])
    else $error("shadow evaluate not taken");
  AST_QUIET: assert property (clk_en && completion_pulse[0] |=> !completion_pulse[0]
    || $past(reevaluate_bit_wr[0]))
    else $error("global pulse repeated without evaluate");

  // ==========================================================
  // pending bit checks
  AST_HI_HOLD: assert property (clk_en && !(wr_en && reg_addr == CCIP_CLR_HI)
    |=> (pend_hi_r & $past(pend_hi_r)) == $past(pend_hi_r))
    else $error("upper pending bit fell without clear");

  AST_CLR_LO_ZERO: assert property (wr_en && reg_addr == CCIP_CLR_LO && reg_wdata == CCIP_ZERO
    |=> pend_lo_r == ($past(pend_lo_r) | $past(set_lo)))
    else $error("lower clear of zero changed pending");

  AST_CLR_HI_ZERO: assert property (wr_en && reg_addr == CCIP_CLR_HI && reg_wdata == CCIP_ZERO
    |=> pend_hi_r == ($past(pend_hi_r) | $past(set_hi)))
    else $error("upper clear of zero changed pending");

  AST_SET_WINS: assert property (wr_en && reg_addr == CCIP_CLR_LO && completion_valid &&
    !completion_code[5] |=> pend_lo_r[$past(code_idx)])
    else $error("clear beat a same-cycle set");

  AST_UPPER_ONLY: assert property (clk_en && completion_valid && completion_code[5] && !wr_en
    |=> pend_lo_r == $past(pend_lo_r))
    else $error("upper code touched lower pending");

  AST_LOWER_ONLY: assert property (clk_en && completion_valid && !completion_code[5] && !wr_en
    |=> pend_hi_r == $past(pend_hi_r))
    else $error("lower code touched upper pending");

  AST_PEND_STILL: assert property (clk_en && !completion_valid && !wr_en
    |=> pend_all == $past(pend_all))
    else $error("pending changed with no event");

  // ==========================================================
  // read and enable checks
  AST_PEND_LO_READ: assert property (rd_en && reg_addr == CCIP_PEND_LO
    |=> reg_rdata == $past(pend_lo_r))
    else $error("lower pending read mismatch");

  AST_REEVALUATE_BIT_READ: assert property (rd_en && reg_addr == CCIP_REEVALUATE_BIT_BASE
    |=> reg_rdata == 32'h0000_0000)
    else $error("evaluate read nonzero");

  AST_RD_IDLE: assert property (clk_en && !rd_en |=> reg_rdata == 32'h0000_0000)
    else $error("read data outside read slot");

  AST_EN_CLR_LO: assert property (wr_en && reg_addr == CCIP_EN_CLR_LO
    |=> (en_lo_r & $past(reg_wdata)) == 32'h0000_0000)
    else $error("lower enable clear did not clear");

  AST_EN_SET_HI: assert property (wr_en && reg_addr == CCIP_EN_SET_HI
    |=> (en_hi_r & $past(reg_wdata)) == $past(reg_wdata))
    else $error("upper enable set did not set");

  AST_EN_SET_ZERO: assert property (wr_en && reg_addr == CCIP_EN_SET_LO && reg_wdata == CCIP_ZERO
    |=> en_lo_r == $past(en_lo_r))
    else $error("enable set of zero changed enable");

  AST_EN_RO: assert property (wr_en && reg_addr == CCIP_EN_LO |=> en_lo_r == $past(en_lo_r))
    else $error("enable word took a direct write");

  // ==========================================================
  // interrupt and freeze checks
  AST_IRQ_LEVEL: assert property (clk_en |=> irq == $past(|(pend_all & en_all)))
    else $error("irq does not follow enabled pending");

  AST_REEVALUATE_BIT_ZERO: assert property (wr_en && reg_addr == CCIP_REEVALUATE_BIT_BASE && !reg_wdata[0]
    |-> !reevaluate_bit_wr[0])
    else $error("evaluate write of zero taken");

  AST_FREEZE_PEND: assert property (!clk_en |=> pend_all == $past(pend_all) &&
    en_all == $past(en_all))
    else $error("state moved with clock enable low");

  AST_FREEZE_RD: assert property (!clk_en |=> reg_rdata == $past(reg_rdata))
    else $error("read data moved with clock enable low");

  COV_UPPER: cover property (clk_en && completion_valid && completion_code[5]);
  COV_CLEAR: cover property (wr_en && reg_addr == CCIP_CLR_LO && |pend_lo_r);
  COV_SHADOW_PULSE: cover property (completion_pulse[1]);

endmodule : ccip_top

// *** dv/ccip_code_src.sv ***
// Purpose: model of the transfer controllers returning completion codes
// Assumes: bench requests one code at a time
// Notes: code lines toggle between strobes so stale codes never look valid

`timescale 1ns/10ps

module ccip_code_src
  import ccip_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic req_valid,
  input wire logic [ccip_pkg::CCIP_CODE_W-1:0] req_code,
  output logic completion_valid,
  output logic [ccip_pkg::CCIP_CODE_W-1:0] completion_code
);
  // ==========================================================
  // one strobe per code, six-bit code field
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      completion_valid <= 1'h0;
      completion_code <= 6'h2a;
    end else begin
      completion_valid <= req_valid;
      completion_code <= req_valid ? req_code : ~completion_code;
    end
  end
endmodule : ccip_code_src

// *** dv/tb_ccip_top.sv ***
// Purpose: self-checking bench for the completion pending block
// Assumes: two shadow regions, clock enable high except during one enable clear write
// Notes: pulses are counted per region and compared with the model

`timescale 1ns/10ps

module tb_ccip_top;
  import ccip_pkg::*;
  localparam int NS = 2;
  logic ref_clk, resetn, clk_en, reg_wr, reg_rd, req_valid, completion_valid, irq;
  ccip_addr_type reg_addr;
  ccip_word_type reg_wdata, reg_rdata, m;
  logic [CCIP_CODE_W-1:0] req_code, completion_code;
  logic [NS*CCIP_NCODE-1:0] acc_en;
  logic [NS:0] completion_pulse;
  logic [7:0] cnt [0:NS];
  logic [7:0] exp_cnt [0:NS];
  logic [63:0] pend, en;
  ccip_addr_type ra [0:7];
  int bad_count, num_checks, seed, i, j, r;

  ccip_top #(.NUM_SHADOW(NS)) u_ccip_top (.ref_clk(ref_clk), .resetn(resetn),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .completion_valid(completion_valid),
    .completion_code(completion_code), .dma_region_access_enable(acc_en),
    .completion_pulse(completion_pulse), .irq(irq));
  ccip_code_src u_ccip_code_src (.ref_clk(ref_clk), .resetn(resetn),
    .req_valid(req_valid), .req_code(req_code),
    .completion_valid(completion_valid), .completion_code(completion_code));

  // ==========================================================
  // clock and pulse counters
  initial begin
    ref_clk = 1'h0;
    forever #10 ref_clk = ~ref_clk;
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    for (int k = 0; k <= NS; k++) begin
      if (!resetn) cnt[k] <= 8'h00;
      else cnt[k] <= cnt[k] + 8'(completion_pulse[k]);
    end
  end

  // ==========================================================
  // model helpers
  function automatic logic [63:0] qual(input int rg);
    return (rg == 0) ? {64{1'h1}} : acc_en[(rg-1)*64 +: 64];
  endfunction : qual
  function automatic logic any_on(input int rg);
    return |(pend & en & qual(rg));
  endfunction : any_on

  task automatic cmp_word(input ccip_word_type got, input ccip_word_type exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected word at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_int(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected interrupt at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp_int

  // ==========================================================
  // bus and code tasks
  task automatic wr(input ccip_addr_type a, input ccip_word_type d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
    repeat (3) @(posedge ref_clk);
  endtask : wr
  task automatic rd_chk(input ccip_addr_type a, input ccip_word_type e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1;
    cmp_word(reg_rdata, e);
  endtask : rd_chk
  task automatic send(input logic [5:0] c);
    @(posedge ref_clk);
    req_valid <= 1'h1;
    req_code <= c;
    @(posedge ref_clk);
    req_valid <= 1'h0;
    for (int k = 0; k <= NS; k++) begin
      if (!any_on(k) && |(qual(k) & en & (64'h1 << c))) exp_cnt[k]++;
    end
    pend[c] = 1'h1;
    repeat (4) @(posedge ref_clk);
  endtask : send
  task automatic reevaluate_bit(input int rg, input ccip_word_type d);
    if (d[0] && any_on(rg)) exp_cnt[rg]++;
    wr(ccip_addr_type'(CCIP_REEVALUATE_BIT_BASE + rg * CCIP_REEVALUATE_BIT_STEP), d);
  endtask : reevaluate_bit
  task automatic check_state;
    rd_chk(CCIP_PEND_LO, pend[31:0]);
    rd_chk(CCIP_PEND_HI, pend[63:32]);
    cmp_int({7'h00, irq}, {7'h00, any_on(0)});
    for (int k = 0; k <= NS; k++) cmp_int(cnt[k], exp_cnt[k]);
  endtask : check_state
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  // ==========================================================
  // watchdog, more than thirty times the expected run
  initial begin
    #400000;
    bad_count++;
    stop_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    seed = 46948;
    {clk_en, resetn, reg_wr, reg_rd, req_valid} = 5'h10;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    req_code = 6'h00;
    acc_en = {$random(seed), $random(seed), $random(seed), $random(seed)};
    {pend, en} = 128'h0;
    exp_cnt = '{default: 8'h00};
    bad_count = 0;
    num_checks = 0;
    ra = '{CCIP_PEND_LO, CCIP_PEND_HI, CCIP_CLR_LO, CCIP_CLR_HI, CCIP_EN_LO, CCIP_EN_HI,
      CCIP_REEVALUATE_BIT_BASE, 8'hfc};
    repeat (20) @(posedge ref_clk);
    resetn <= 1'h1;
    for (i = 0; i < 8; i++) rd_chk(ra[i], 32'h0);
    wr(CCIP_EN_SET_LO, 32'hffff_ffff);
    wr(CCIP_EN_SET_HI, 32'hffff_ffff);
    wr(CCIP_EN_SET_LO, 32'h0);
    en = {64{1'h1}};
    wr(CCIP_EN_CLR_HI, 32'h0000_ff00);
    en[47:40] = 8'h00;
    rd_chk(CCIP_EN_LO, 32'hffff_ffff);
    rd_chk(CCIP_EN_HI, 32'hffff_00ff);
    @(posedge ref_clk);
    clk_en <= 1'h0;
    wr(CCIP_EN_CLR_LO, 32'hffff_ffff);
    clk_en <= 1'h1;
    rd_chk(CCIP_EN_LO, 32'hffff_ffff);
    for (j = 0; j < 2; j++) begin
      for (i = 0; i < 14; i++) begin
        send((i < 4) ? 6'(32'h1f3f_201f >> (8 * i)) : 6'($random(seed)));
        check_state();
      end
      for (r = 0; r <= NS; r++) begin
        reevaluate_bit(r, 32'h1);
        reevaluate_bit(r, 32'h0);
        check_state();
      end
      m = $random(seed);
      wr(CCIP_CLR_LO, m);
      wr(CCIP_CLR_LO, 32'h0);
      pend[31:0] = pend[31:0] & ~m;
      m = $random(seed);
      wr(CCIP_CLR_HI, m);
      wr(CCIP_CLR_HI, 32'h0);
      pend[63:32] = pend[63:32] & ~m;
      check_state();
      reevaluate_bit(0, 32'h1);
      check_state();
      wr(CCIP_CLR_LO, 32'hffff_ffff);
      wr(CCIP_CLR_HI, 32'hffff_ffff);
      pend = 64'h0;
      reevaluate_bit(0, 32'h1);
      check_state();
      acc_en <= {$random(seed), $random(seed), $random(seed), $random(seed)};
    end
    send(6'h21);
    check_state();
    stop_test();
  end
endmodule : tb_ccip_top
